// ===== rtl/pcs_consts.svh
// offsets, field positions, reset values and sizes of the program counter and call stack
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define PCS_OFF_STACK_TOP_HIGH 8'h16
`define PCS_OFF_STACK_TOP_LOW 8'h17
`define PCS_OFF_STACK_CTRL 8'h18
`define PCS_OFF_PC_HIGH_LATCH 8'h1A
`define PCS_OFF_PC_LOW_BYTE 8'h1B
`define PCS_OFF_POWER_STATUS 8'h2C
`define PCS_OFF_PROG_CTRL 8'h30
`define PCS_OFF_PROG_ADDR_LOW 8'h31
`define PCS_OFF_PROG_ADDR_HIGH 8'h32
`define PCS_OFF_PROG_DATA_LOW 8'h33
`define PCS_OFF_PROG_DATA_HIGH 8'h34
`define PCS_BIT_FULL 7
`define PCS_BIT_UNDER 6
`define PCS_BIT_OVER 5
`define PCS_BIT_STKERR 2
`define PCS_BIT_PROTECT 0
`define PCS_BIT_PROG_WRITE 1
`define PCS_RST_BYTE 8'h00
`define PCS_RST_PC 14'h0000
`define PCS_RST_LEVEL 5'h00
`define PCS_MAX_LEVEL 5'h10
`define PCS_BLANK_WORD 16'hFFFF
`define PCS_PROG_WORDS 256
`endif

// ===== rtl/pcs_core.sv
// program counter, return-address stack and their wishbone register file
//
// Behaviour
// RQ1: blank program words read all ones; programmed words read back as written.
// RQ2: with protection selected every program memory read returns zero.
// RQ3: program counter is 14 bits: 6-bit upper shadow plus 8-bit low byte.
// RQ4: upper shadow is reached only through the 6-bit high latch register.
// RQ5: reading the low byte captures the upper bits into the high latch.
// RQ6: writing the low byte loads latch plus written byte into the counter.
// RQ7: call or interrupt increments the level and stores the counter on top.
// RQ8: return loads the counter from top, then the level decrements.
// RQ9: top-of-stack bytes are readable at any time in any order.
// RQ10: pop discards the top entry, decrements level, counter untouched.
// RQ11: pop at level zero flags nothing and keeps level at zero.
// RQ12: reaching full sets the full flag; counter unaffected.
// RQ13: underflow sets its flag, zeroes counter and level.
// RQ14: overflow sets its flag; top layer is overwritten with the newest value.
// RQ15: with error reset enabled, stack errors reset the core and set error flag.
// RQ16: error reset enable is a strap, invisible to software.
// RQ17: 5-bit level spans zero to sixteen; level zero shows top as zero.
// RQ18: error flag reads one after a stack error reset, else zero.
// RQ19: software should clear flags after a combined overflow and underflow.
// RQ20: program space is up to twenty address bits; this part implements fewer.
// RQ21: stack flags stay set until software clears them or a reset.
//
// register map, one byte per word, data in the low lane:
//   0x16 stack top high: bits 5:0 upper part of the entry at the current level
//   0x17 stack top low: bits 7:0 lower part of the entry at the current level
//   0x18 stack control: bit7 full, bit6 underflow, bit5 overflow, bits 4:0 level
//   0x1A pc high latch: bits 5:0, loaded by software or by a low-byte read
//   0x1B pc low byte: read gives pc[7:0], write loads the whole counter
//   0x2C power status: bit2 stack error reset flag, other bits read zero
//   0x30 program control: bit0 protect (sticky), bit1 program strobe
//   0x31 program address, 0x33 / 0x34 program data low / high
//
// bus timing, classic single cycle with one wait state:
//   taking edge: request seen with no ack pending; read data and the latch
//   capture of a low-byte read happen here
//   answer edge: ack (or err) is high; a write takes effect only here, so a
//   master that aborts before ack leaves no trace in the registers
//   ack drops by itself one cycle later; the master must drop cyc and stb
//
// stack behaviour and limits:
//   level 0 is the empty stack, layers 1 to 16 hold return addresses
//   a push at level 15 reaches full; a push at 16 overflows and rewrites 16
//   a pop at level 0 is silently ignored, a return at level 0 underflows
//   the error reset is a one-cycle internal pulse; the power status flag
//   survives it so software can tell why the core restarted
//   clk_en low freezes the counter and the stack, and holds ack and err low
//
// Local design decision: the Wishbone register port.
`include "pcs_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module pcs_core (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic error_reset_strap,
  input wire pcs_pkg::pcs_op_type stack_op,
  input wire logic pc_advance,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic [13:0] pc_out,
  output logic [15:0] prog_word,
  output logic stack_error_reset
);
  import pcs_pkg::*;

  pcs_addr_type pc_r;
  logic [5:0] pc_high_latch_r;
  pcs_level_type level_r;
  pcs_addr_type layer_r [1:16];
  logic full_r, over_r, under_r, stkerr_r, enable_r, core_rst_r, ack_r;
  logic protect_r;
  logic [7:0] prog_addr_r;
  logic [15:0] prog_data_r;
  logic [15:0] prog_mem [0:`PCS_PROG_WORDS-1];
  logic [`PCS_PROG_WORDS-1:0] programmed_r;
  logic [15:0] prog_word_nxt;
  pcs_addr_type top_view;
  logic [7:0] reg_addr, wbyte, rbyte;
  logic acc, rd_stb, wr_stb, mapped;
  logic push_ev, ret_ev, pop_ev, over_ev, under_ev, full_ev;
  logic soft_rst;

  // window check: registers live below byte address 0x400 only
  // used by the read strobe and both answer outputs, so kept in one place
  function automatic logic addr_ok(input logic [31:0] adr);
    addr_ok = adr[31:10] == 22'h000000;
  endfunction

  // word decode: registers sit at four times their index, low lane holds data
  assign reg_addr = wb_adr_i[9:2];
  assign acc = wb_cyc_i && wb_stb_i && !ack_r;
  assign wbyte = wb_dat_i[7:0];
  always_comb begin
    unique case (reg_addr)
      `PCS_OFF_STACK_TOP_HIGH, `PCS_OFF_STACK_TOP_LOW, `PCS_OFF_STACK_CTRL,
      `PCS_OFF_PC_HIGH_LATCH, `PCS_OFF_PC_LOW_BYTE, `PCS_OFF_POWER_STATUS,
      `PCS_OFF_PROG_CTRL, `PCS_OFF_PROG_ADDR_LOW, `PCS_OFF_PROG_ADDR_HIGH,
      `PCS_OFF_PROG_DATA_LOW, `PCS_OFF_PROG_DATA_HIGH: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  // upper address bits must be zero, otherwise unmapped
  assign rd_stb = clk_en && acc && !wb_we_i && mapped && addr_ok(wb_adr_i);
  // a write lands on the edge at which the master sees ack, not when taken;
  // ack only rises for a mapped address, and the master holds it until then
  assign wr_stb = clk_en && wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

  // level zero shows an empty top [RQ17] [RQ9]
  assign top_view = (level_r == `PCS_RST_LEVEL) ? `PCS_RST_PC : layer_r[level_r];

  // stack events from the sequencer
  assign push_ev = clk_en && stack_op == PCS_OP_PUSH;
  assign ret_ev = clk_en && stack_op == PCS_OP_RETURN;
  assign pop_ev = clk_en && stack_op == PCS_OP_POP;
  assign full_ev = push_ev && level_r == `PCS_MAX_LEVEL - 5'h01; // [RQ12]
  assign over_ev = push_ev && level_r == `PCS_MAX_LEVEL; // [RQ14]
  assign under_ev = ret_ev && level_r == `PCS_RST_LEVEL; // [RQ13] pop excluded [RQ11]
  assign soft_rst = reset || core_rst_r;

  // strap sampled on every enabled clock after power-on reset, never by software [RQ16]
  always_ff @(posedge mclk) begin
    if (reset) begin
      enable_r <= 1'b0;
    end else if (clk_en) begin
      enable_r <= error_reset_strap;
    end
  end

  // one-cycle core reset pulse on a stack error when enabled [RQ15]
  always_ff @(posedge mclk) begin
    if (reset) begin
      core_rst_r <= 1'b0;
    end else if (clk_en) begin
      core_rst_r <= enable_r && (over_ev || under_ev);
    end
  end
  assign stack_error_reset = core_rst_r;

  // error flag survives the core reset it causes; only power reset or write clears [RQ18]
  always_ff @(posedge mclk) begin
    if (reset) begin
      stkerr_r <= 1'b0;
    end else if (core_rst_r) begin
      stkerr_r <= 1'b1; // [RQ15]
    end else if (wr_stb && reg_addr == `PCS_OFF_POWER_STATUS) begin
      stkerr_r <= wbyte[`PCS_BIT_STKERR];
    end
  end

  // stack level pointer
  always_ff @(posedge mclk) begin
    if (soft_rst) begin
      level_r <= `PCS_RST_LEVEL;
    end else if (push_ev && !over_ev) begin
      level_r <= level_r + 5'h01; // [RQ7]
    end else if ((ret_ev || pop_ev) && level_r != `PCS_RST_LEVEL) begin
      level_r <= level_r - 5'h01; // [RQ8] [RQ10] [RQ11]
    end else if (under_ev) begin
      level_r <= `PCS_RST_LEVEL; // [RQ13]
    end
  end

  // stack layers; overflow rewrites the top layer [RQ14]
  always_ff @(posedge mclk) begin
    if (push_ev && !soft_rst) begin
      layer_r[over_ev ? `PCS_MAX_LEVEL : level_r + 5'h01] <= pc_r; // [RQ7]
    end else if (!soft_rst && wr_stb && level_r != `PCS_RST_LEVEL) begin
      if (reg_addr == `PCS_OFF_STACK_TOP_LOW) begin
        layer_r[level_r][7:0] <= wbyte;
      end else if (reg_addr == `PCS_OFF_STACK_TOP_HIGH) begin
        layer_r[level_r][13:8] <= wbyte[5:0];
      end
    end
  end

  // sticky flags, set wins over a software clear [RQ21]
  always_ff @(posedge mclk) begin
    if (soft_rst) begin
      full_r <= 1'b0; // flags read zero after the error reset [RQ15]
      over_r <= 1'b0;
      under_r <= 1'b0;
    end else begin
      if (wr_stb && reg_addr == `PCS_OFF_STACK_CTRL) begin
        full_r <= wbyte[`PCS_BIT_FULL] | full_ev;
        over_r <= wbyte[`PCS_BIT_OVER] | over_ev;
        under_r <= wbyte[`PCS_BIT_UNDER] | under_ev;
      end else begin
        full_r <= full_r | full_ev; // [RQ12]
        over_r <= over_r | over_ev; // [RQ14]
        under_r <= under_r | under_ev; // [RQ13]
      end
    end
  end

  // high latch: captured on a low-byte read, or written by software [RQ4] [RQ5]
  always_ff @(posedge mclk) begin
    if (soft_rst) begin
      pc_high_latch_r <= 6'h00;
    end else if (rd_stb && reg_addr == `PCS_OFF_PC_LOW_BYTE) begin
      pc_high_latch_r <= pc_r[13:8]; // [RQ5]
    end else if (wr_stb && reg_addr == `PCS_OFF_PC_HIGH_LATCH) begin
      pc_high_latch_r <= wbyte[5:0]; // [RQ6]
    end
  end

  // program counter; stack returns beat the sequencer's advance [RQ3]
  always_ff @(posedge mclk) begin
    if (soft_rst) begin
      pc_r <= `PCS_RST_PC;
    end else if (under_ev) begin
      pc_r <= `PCS_RST_PC; // [RQ13]
    end else if (ret_ev) begin
      pc_r <= top_view; // [RQ8]
    end else if (wr_stb && reg_addr == `PCS_OFF_PC_LOW_BYTE) begin
      pc_r <= {pc_high_latch_r, wbyte}; // [RQ6] [RQ4]
    end else if (clk_en && pc_advance) begin
      pc_r <= pc_r + 14'h0001; // full and overflow leave it alone [RQ12] [RQ14]
    end
  end
  assign pc_out = pc_r;

  // program memory window: address, data, protection [RQ20]
  always_ff @(posedge mclk) begin
    if (reset) begin
      protect_r <= 1'b0;
      prog_addr_r <= `PCS_RST_BYTE;
      prog_data_r <= 16'h0000;
    end else if (wr_stb) begin
      if (reg_addr == `PCS_OFF_PROG_CTRL) begin
        protect_r <= protect_r | wbyte[`PCS_BIT_PROTECT]; // one-way, like a fuse
      end
      if (reg_addr == `PCS_OFF_PROG_ADDR_LOW) begin
        prog_addr_r <= wbyte;
      end
      if (reg_addr == `PCS_OFF_PROG_DATA_LOW) begin
        prog_data_r[7:0] <= wbyte;
      end
      if (reg_addr == `PCS_OFF_PROG_DATA_HIGH) begin
        prog_data_r[15:8] <= wbyte;
      end
    end
  end

  // programming strobe: cells rewritable until protected, blank marks kept per word [RQ1]
  always_ff @(posedge mclk) begin
    if (reset) begin
      programmed_r <= '0;
    end else if (wr_stb && reg_addr == `PCS_OFF_PROG_CTRL && wbyte[`PCS_BIT_PROG_WRITE]
        && !protect_r) begin
      programmed_r[prog_addr_r] <= 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (wr_stb && reg_addr == `PCS_OFF_PROG_CTRL && wbyte[`PCS_BIT_PROG_WRITE]
        && !protect_r) begin
      prog_mem[prog_addr_r] <= prog_data_r;
    end
  end

  // fetch word at the counter, registered
  always_comb begin
    if (protect_r) begin
      prog_word_nxt = 16'h0000; // [RQ2]
    end else if (!programmed_r[pc_r[7:0]]) begin
      prog_word_nxt = `PCS_BLANK_WORD; // [RQ1]
    end else begin
      prog_word_nxt = prog_mem[pc_r[7:0]];
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      prog_word <= 16'h0000;
    end else if (clk_en) begin
      prog_word <= prog_word_nxt;
    end
  end

  // read mux; reserved bits read zero
  always_comb begin
    rbyte = `PCS_RST_BYTE;
    unique case (reg_addr)
      `PCS_OFF_STACK_TOP_HIGH: rbyte = {2'b00, top_view[13:8]}; // [RQ9]
      `PCS_OFF_STACK_TOP_LOW: rbyte = top_view[7:0];
      `PCS_OFF_STACK_CTRL: rbyte = {full_r, under_r, over_r, level_r};
      `PCS_OFF_PC_HIGH_LATCH: rbyte = {2'b00, pc_high_latch_r};
      `PCS_OFF_PC_LOW_BYTE: rbyte = pc_r[7:0];
      `PCS_OFF_POWER_STATUS: rbyte = {5'h00, stkerr_r, 2'b00}; // [RQ18]
      `PCS_OFF_PROG_CTRL: rbyte = {7'h00, protect_r};
      `PCS_OFF_PROG_ADDR_LOW: rbyte = prog_addr_r;
      `PCS_OFF_PROG_DATA_LOW: rbyte = protect_r ? 8'h00 : prog_data_r[7:0];
      `PCS_OFF_PROG_DATA_HIGH: rbyte = protect_r ? 8'h00 : prog_data_r[15:8];
      default: rbyte = `PCS_RST_BYTE;
    endcase
  end

  // one-wait-state slave: ack or err one cycle after the strobe, data registered
  always_ff @(posedge mclk) begin
    if (reset) begin
      ack_r <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en) begin
      ack_r <= acc;
      wb_ack_o <= acc && mapped && addr_ok(wb_adr_i);
      wb_err_o <= acc && !(mapped && addr_ok(wb_adr_i));
      wb_dat_o <= (acc && !wb_we_i) ? {24'h000000, rbyte} : 32'h0000_0000;
    end else begin
      ack_r <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/pcs_pkg.sv
// types shared by the program counter and call stack
package pcs_pkg;
  typedef logic [13:0] pcs_addr_type;
  typedef logic [4:0] pcs_level_type;
  typedef enum logic [1:0] {
    PCS_OP_NONE,
    PCS_OP_PUSH,
    PCS_OP_RETURN,
    PCS_OP_POP
  } pcs_op_type;
endpackage

// ===== tb/pcs_core_props.sv
// port-level assertions for the program counter and call stack
`timescale 1ns/10ps
`default_nettype none
module pcs_core_props (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic error_reset_strap,
  input wire pcs_pkg::pcs_op_type stack_op,
  input wire logic pc_advance,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [13:0] pc_out,
  input wire logic [15:0] prog_word,
  input wire logic stack_error_reset
);
  import pcs_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // bus answer timing and shape
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  bus_answer_a: assert property (wb_cyc_i && wb_stb_i && clk_en && !wb_ack_o && !wb_err_o
    |=> wb_ack_o || wb_err_o) else $error("request not answered next cycle");
  data_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bytes not zero");
  // counter stepping and freezing
  pc_step_a: assert property (clk_en && pc_advance && stack_op == PCS_OP_NONE
    && !stack_error_reset && !(wb_cyc_i && wb_we_i) |=> pc_out == $past(pc_out) + 14'h0001)
    else $error("counter did not step by one");
  pc_freeze_a: assert property (!clk_en && !stack_error_reset |=> $stable(pc_out))
    else $error("counter moved while frozen");
  // stack error reset
  err_clear_a: assert property (stack_error_reset |=> pc_out == 14'h0000)
    else $error("counter not cleared by error reset");
  err_pulse_a: assert property (stack_error_reset |=> !stack_error_reset)
    else $error("error reset longer than one cycle");
  strap_gate_a: assert property (stack_error_reset |-> $past(error_reset_strap))
    else $error("error reset without enable strap");
endmodule
`default_nettype wire

// ===== tb/pcs_core_test.sv
// self-checking bench for the program counter and call stack
`timescale 1ns/10ps
`default_nettype none
module pcs_core_test;
  import pcs_pkg::*;
  logic mclk, reset, clk_en, strap, req, adv, we, cyc, stb, ack, err, ser, pa, e;
  pcs_op_type rop, sop;
  logic [31:0] adr, wdat, rdat;
  logic [13:0] pc;
  logic [15:0] pword;
  logic [7:0] rd;
  int miscompares, check_count;
  pcs_seq_model u_pcs_seq_model (.mclk(mclk), .reset(reset), .req(req), .req_op(rop),
    .req_adv(adv), .stack_op(sop), .pc_advance(pa));
  pcs_core u_pcs_core (.mclk(mclk), .reset(reset), .clk_en(clk_en), .error_reset_strap(strap),
    .stack_op(sop), .pc_advance(pa), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .wb_err_o(err), .pc_out(pc), .prog_word(pword), .stack_error_reset(ser));
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    check_count++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  // classic single cycle; waits for the answer, bounded so a hang is caught
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {22'h000000, a, 2'b00};
    wdat <= {24'h000000, d};
    do begin
      @(posedge mclk);
      n++;
    end while (!ack && !err && n < 50);
    rd = rdat[7:0];
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) miscompares++;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] x);
    wb(a, 1'b0, 8'h00);
    chk(n, {8'h00, x}, {8'h00, rd});
  endtask
  task automatic op(input pcs_op_type o, input logic a);
    @(posedge mclk);
    req <= 1'b1;
    rop <= o;
    adv <= a;
    @(posedge mclk);
    req <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic do_reset;
    @(posedge mclk);
    reset <= 1'b1;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
  endtask
  task automatic t_reset;
    rchk("level", 8'h18, 8'h00);
    rchk("latch", 8'h1A, 8'h00);
    rchk("top high", 8'h16, 8'h00);
    wb(8'h2C, 1'b0, 8'h00);
    chk("err flag", 16'h0000, {15'h0000, rd[2]});
    chk("blank word", 16'hFFFF, pword);
    wb(8'h3F, 1'b0, 8'h00);
    chk("unmapped", 16'h0001, {15'h0000, e});
  endtask
  // low byte carries across into the upper part before the ordered read
  task automatic t_pc;
    wb(8'h1A, 1'b1, 8'h2A);
    wb(8'h1B, 1'b1, 8'hFF);
    @(posedge mclk);
    chk("pc load", 16'h2AFF, {2'b00, pc});
    op(PCS_OP_NONE, 1'b1);
    chk("pc step", 16'h2B00, {2'b00, pc});
    rchk("pc low", 8'h1B, 8'h00);
    rchk("pc high", 8'h1A, 8'h2B);
    @(posedge mclk);
    clk_en <= 1'b0;
    req <= 1'b1;
    adv <= 1'b1;
    repeat (2) @(posedge mclk);
    req <= 1'b0;
    adv <= 1'b0;
    @(posedge mclk);
    clk_en <= 1'b1;
    chk("pc frozen", 16'h2B00, {2'b00, pc});
  endtask
  task automatic t_stack;
    for (int i = 0; i < 16; i++) begin
      op(PCS_OP_NONE, 1'b1);
      op(PCS_OP_PUSH, 1'b0);
    end
    rchk("full", 8'h18, 8'h90);
    chk("pc at full", 16'h2B10, {2'b00, pc});
    rchk("top low", 8'h17, 8'h10);
    rchk("top high", 8'h16, 8'h2B);
    op(PCS_OP_NONE, 1'b1);
    op(PCS_OP_PUSH, 1'b0);
    rchk("overflow", 8'h18, 8'hB0);
    rchk("overwritten", 8'h17, 8'h11);
    op(PCS_OP_POP, 1'b0);
    rchk("pop level", 8'h18, 8'hAF);
    rchk("pop top", 8'h17, 8'h0F);
    chk("pc after pop", 16'h2B11, {2'b00, pc});
    op(PCS_OP_RETURN, 1'b0);
    chk("pc return", 16'h2B0F, {2'b00, pc});
    rchk("ret level", 8'h18, 8'hAE);
    rchk("ret top", 8'h17, 8'h0E);
  endtask
  task automatic t_under;
    repeat (15) op(PCS_OP_POP, 1'b0);
    rchk("pop at zero", 8'h18, 8'hA0);
    rchk("empty top", 8'h17, 8'h00);
    op(PCS_OP_RETURN, 1'b0);
    rchk("underflow", 8'h18, 8'hE0);
    chk("pc underflow", 16'h0000, {2'b00, pc});
  endtask
  task automatic t_err;
    strap <= 1'b1;
    do_reset;
    op(PCS_OP_RETURN, 1'b0);
    rchk("flags cleared", 8'h18, 8'h00);
    wb(8'h2C, 1'b0, 8'h00);
    chk("err flag", 16'h0001, {15'h0000, rd[2]});
    wb(8'h30, 1'b1, 8'h01);
    repeat (3) @(posedge mclk);
    chk("protected", 16'h0000, pword);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // watchdog: the full sequence needs well under a tenth of this span
  initial begin
    #40000;
    miscompares++;
    finish_test;
  end
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    strap = 1'b0;
    req = 1'b0;
    rop = PCS_OP_NONE;
    adv = 1'b0;
    {we, cyc, stb} = 3'h0;
    adr = 32'h00000000;
    wdat = 32'h00000000;
    miscompares = 0;
    check_count = 0;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    t_reset;
    t_pc;
    t_stack;
    t_under;
    t_err;
    finish_test;
  end
endmodule
bind pcs_core pcs_core_props u_pcs_core_props (.*);
`default_nettype wire

// ===== tb/pcs_seq_model.sv
// instruction sequencer stand-in: one stack operation per request
`timescale 1ns/10ps
`default_nettype none
module pcs_seq_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic req,
  input wire pcs_pkg::pcs_op_type req_op,
  input wire logic req_adv,
  output var pcs_pkg::pcs_op_type stack_op,
  output logic pc_advance
);
  import pcs_pkg::*;
  // idle between requests so an operation is never repeated by accident
  always_ff @(posedge mclk) begin
    stack_op <= (req && !reset) ? req_op : PCS_OP_NONE;
    pc_advance <= req && req_adv && !reset;
  end
endmodule
`default_nettype wire
